/* include/aab_defines.vh */
// Constants for the add and bit-AND execution block
// Operation
// RULE_01 - Byte add is decoded from opcodes 02 (2 bytes, 4 cycles), 03 (2 bytes, 6 cycles) and 04/05/06 (3 bytes, 6 cycles).
// RULE_02 - Logical AND combines source and destination bit by bit and writes the result to the destination.
// RULE_03 - Each AND result bit is one only when both matching operand bits are one.
// RULE_04 - After AND, zero is set for a zero result and sign copies result bit 7.
// RULE_05 - After AND, overflow is cleared and carry, decimal-adjust and half-carry are kept.
// RULE_06 - Bit AND combines one selected bit with bit 0 of a working register and writes that one bit only.
// RULE_07 - Bit AND is opcode 67, 3 bytes, 6 cycles; byte two holds register, bit index and direction flag.
// RULE_08 - After bit AND, zero follows the result, sign is cleared, overflow is undefined, others kept.
// RULE_09 - Byte add writes the two's complement sum to the destination and leaves the source alone.
// RULE_10 - After add, overflow flags a sign change from same-sign operands; carry, zero, sign follow; decimal-adjust cleared.
// RULE_11 - After add, half-carry is set on a carry out of the low four bits.
`ifndef AAB_DEFINES_VH
`define AAB_DEFINES_VH
`define AAB_OP_ADD_RR   8'h02
`define AAB_OP_ADD_RIR  8'h03
`define AAB_OP_ADD_GG   8'h04
`define AAB_OP_ADD_GIG  8'h05
`define AAB_OP_ADD_GIM  8'h06
`define AAB_OP_AND_RR   8'h52
`define AAB_OP_AND_RIR  8'h53
`define AAB_OP_AND_GG   8'h54
`define AAB_OP_AND_GIG  8'h55
`define AAB_OP_AND_GIM  8'h56
`define AAB_OP_BAND     8'h67
`define AAB_CYC_SHORT   4'h4
`define AAB_CYC_LONG    4'h6
`define AAB_CNT_BIAS    4'h2
`define AAB_LEN_TWO     2'h2
`define AAB_LEN_THREE   2'h3
`define AAB_FLAG_C      7
`define AAB_FLAG_Z      6
`define AAB_FLAG_S      5
`define AAB_FLAG_V      4
`define AAB_FLAG_D      3
`define AAB_FLAG_H      2
`define AAB_BYTE2_DIR   0
`define AAB_BYTE2_BIT_LO 1
`define AAB_BYTE2_REG_LO 4
`define AAB_FLAGS_RESET 8'h00
`endif

/* src/aab_exec.v */
// Execution datapath for byte add, byte AND and bit AND
`timescale 1ns/1ps
`include "aab_defines.vh"
module aab_exec (
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	input  wire       ce,
	// Instruction issue
	input  wire       start,
	input  wire [7:0] opcode,
	input  wire [7:0] byte2,
	input  wire [7:0] dstVal,
	input  wire [7:0] srcVal,
	input  wire [7:0] flagsIn,
	// Results
	output reg        done,
	output reg        known,
	output reg  [7:0] result,
	output reg  [7:0] flagsOut,
	output reg        writeDst,
	output reg        writeWorking,
	output reg  [3:0] workingReg,
	output reg  [1:0] instrLen,
	output reg  [3:0] instrCycles,
	output reg        busy
);

	// Two states are enough: every op is one take, a count, then done
	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;

	reg       state;
	reg [3:0] count;
	reg [7:0] next_result;
	reg [7:0] next_flags;
	reg       next_known;
	reg       next_toWorking;
	reg [1:0] next_len;
	reg [3:0] next_cyc;
	// Widened sums carry out the carry and half-carry
	reg [8:0] sum;
	reg [4:0] lowSum;
	reg       bitRes;
	reg [2:0] bitIdx;
	reg       isAdd;
	reg       isAnd;
	reg       isBand;

	// Write targets held from the take until done releases them
	reg       dirWorking;
	reg       destWrite;

	// Opcode family test, shared by add and AND decoding
	function inFamily;
		input [7:0] op;
		input [7:0] base;
		begin
			inFamily = (op >= base) && (op <= base + 8'h04);
		end
	endfunction

	// Result-is-zero test, shared by the add and AND flag updates
	function isZero;
		input [7:0] v;
		begin
			isZero = (v == 8'h00);
		end
	endfunction

	// Pick one bit of a byte by index
	function pickBit;
		input [7:0] v;
		input [2:0] idx;
		begin
			pickBit = v[idx];
		end
	endfunction

	// Replace one bit of a byte, the other seven stay intact
	function [7:0] putBit;
		input [7:0] v;
		input [2:0] idx;
		input       b;
		begin
			putBit      = v;
			putBit[idx] = b;
		end
	endfunction

	// Instruction class, decoded once for the datapath below
	always @* begin
		isAdd  = inFamily(opcode, `AAB_OP_ADD_RR);
		isAnd  = inFamily(opcode, `AAB_OP_AND_RR);
		isBand = (opcode == `AAB_OP_BAND); // RULE_07
	end

	// Flags start from flagsIn so untouched bits pass through
	always @* begin
		next_result    = dstVal;
		next_flags     = flagsIn;
		next_known     = 1'b1;
		next_toWorking = 1'b0;
		next_len       = `AAB_LEN_THREE;
		next_cyc       = `AAB_CYC_LONG;
		sum            = {1'b0, dstVal} + {1'b0, srcVal};
		lowSum         = {1'b0, dstVal[3:0]} + {1'b0, srcVal[3:0]};
		bitIdx         = byte2[`AAB_BYTE2_BIT_LO+2:`AAB_BYTE2_BIT_LO];
		bitRes         = 1'b0;
		if (isAdd) begin
			if (opcode == `AAB_OP_ADD_RR) begin
				next_len = `AAB_LEN_TWO; // RULE_01
				next_cyc = `AAB_CYC_SHORT; // RULE_01
			end else if (opcode == `AAB_OP_ADD_RIR) begin
				next_len = `AAB_LEN_TWO; // RULE_01
			end
			next_result = sum[7:0]; // RULE_09
			next_flags[`AAB_FLAG_C] = sum[8]; // RULE_10
			next_flags[`AAB_FLAG_Z] = isZero(sum[7:0]); // RULE_10
			next_flags[`AAB_FLAG_S] = sum[7]; // RULE_10
			next_flags[`AAB_FLAG_V] = (dstVal[7] == srcVal[7]) && (sum[7] != dstVal[7]); // RULE_10
			next_flags[`AAB_FLAG_D] = 1'b0; // RULE_10
			next_flags[`AAB_FLAG_H] = lowSum[4]; // RULE_11
		end else if (isAnd) begin
			if (opcode == `AAB_OP_AND_RR) begin
				next_len = `AAB_LEN_TWO;
				next_cyc = `AAB_CYC_SHORT;
			end else if (opcode == `AAB_OP_AND_RIR) begin
				next_len = `AAB_LEN_TWO;
			end
			next_result = dstVal & srcVal; // RULE_02 RULE_03
			next_flags[`AAB_FLAG_Z] = isZero(dstVal & srcVal); // RULE_04
			next_flags[`AAB_FLAG_S] = dstVal[7] & srcVal[7]; // RULE_04
			next_flags[`AAB_FLAG_V] = 1'b0; // RULE_05
			next_flags[`AAB_FLAG_C] = flagsIn[`AAB_FLAG_C]; // RULE_05
			next_flags[`AAB_FLAG_D] = flagsIn[`AAB_FLAG_D]; // RULE_05
			next_flags[`AAB_FLAG_H] = flagsIn[`AAB_FLAG_H]; // RULE_05
		end else if (isBand) begin
			// Direction 0: working register is dst; 1: selected bit of dstVal is dst
			next_toWorking = ~byte2[`AAB_BYTE2_DIR]; // RULE_07
			if (!byte2[`AAB_BYTE2_DIR]) begin
				bitRes      = dstVal[0] & pickBit(srcVal, bitIdx); // RULE_06
				next_result = putBit(dstVal, 3'h0, bitRes); // RULE_06
			end else begin
				bitRes      = pickBit(dstVal, bitIdx) & srcVal[0]; // RULE_06
				next_result = putBit(dstVal, bitIdx, bitRes); // RULE_06
			end
			next_flags[`AAB_FLAG_Z] = ~bitRes; // RULE_08
			next_flags[`AAB_FLAG_S] = 1'b0; // RULE_08
			// Overflow is undefined here; holding it keeps results deterministic
			next_flags[`AAB_FLAG_V] = flagsIn[`AAB_FLAG_V]; // RULE_08
			next_flags[`AAB_FLAG_C] = flagsIn[`AAB_FLAG_C]; // RULE_08
			next_flags[`AAB_FLAG_D] = flagsIn[`AAB_FLAG_D]; // RULE_08
			next_flags[`AAB_FLAG_H] = flagsIn[`AAB_FLAG_H]; // RULE_08
		end else begin
			// Unknown opcodes run the short count with no write strobes
			next_known = 1'b0;
			next_len   = 2'h1;
			next_cyc   = `AAB_CYC_SHORT;
		end
	end

	// ce gates all but reset, so a stalled core keeps its place
	always @(posedge clk) begin
		if (rst) begin
			state        <= ST_IDLE;
			count        <= 4'h0;
			done         <= 1'b0;
			known        <= 1'b0;
			result       <= 8'h00;
			flagsOut     <= `AAB_FLAGS_RESET;
			writeDst     <= 1'b0;
			writeWorking <= 1'b0;
			workingReg   <= 4'h0;
			instrLen     <= 2'h0;
			instrCycles  <= 4'h0;
			busy         <= 1'b0;
			dirWorking   <= 1'b0;
			destWrite    <= 1'b0;
		end else if (ce) begin
			done         <= 1'b0;
			writeDst     <= 1'b0;
			writeWorking <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (start) begin
						// Operands are captured now; the result is held until done
						result      <= next_result;
						flagsOut    <= next_flags;
						known       <= next_known;
						instrLen    <= next_len;
						instrCycles <= next_cyc;
						workingReg  <= byte2[`AAB_BYTE2_REG_LO+3:`AAB_BYTE2_REG_LO]; // RULE_07
						writeWorking <= 1'b0;
						// The take and done edges fall outside the count
						count       <= next_cyc - `AAB_CNT_BIAS;
						busy        <= 1'b1;
						state       <= ST_WAIT;
						// Working-register target is remembered in known-path below
						writeDst    <= 1'b0;
						dirWorking  <= next_toWorking & next_known;
						destWrite   <= next_known & ~next_toWorking;
					end
				end
				ST_WAIT: begin
					// Write strobes leave with done so the register file sees one pulse
					if (count == 4'h0) begin
						state        <= ST_IDLE;
						busy         <= 1'b0;
						done         <= 1'b1; // RULE_01
						writeDst     <= destWrite;
						writeWorking <= dirWorking;
					end else begin
						count <= count - 4'h1;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

endmodule // aab_exec

/* bench/aab_exec_props.sv */
// Port assertions for the execution block
`timescale 1ns/1ps
module aab_exec_props (
	// Clock and issue
	input wire       clk,
	input wire       rst,
	input wire       ce,
	input wire       start,
	input wire [7:0] opcode,
	input wire [7:0] dstVal,
	input wire [7:0] srcVal,
	input wire [7:0] flagsIn,
	// Watched results
	input wire       done,
	input wire       known,
	input wire       writeDst,
	input wire       busy,
	input wire [7:0] result,
	input wire [7:0] flagsOut
);
	default clocking @(posedge clk); endclocking
	// A frozen clock enable stretches every count
	default disable iff (rst || !ce);
	wire tk = ce && start && !busy;
	wire isAdd = opcode > 8'h01 && opcode < 8'h07;
	wire isAnd = opcode > 8'h51 && opcode < 8'h57;
	wire isShort = opcode == 8'h02 || opcode == 8'h52;
	sequence takeAdd; tk && isAdd; endsequence
	sequence takeAnd; tk && isAnd; endsequence
	short_op_time_a: assert property (tk && isShort |=> busy[*3] ##1 done && !busy) else $error("short op timing");
	long_op_time_a: assert property (tk && !isShort && (isAdd || isAnd || opcode == 8'h67) |=> busy[*5] ##1 done)
		else $error("long op timing");
	and_value_a: assert property (takeAnd |=> result == ($past(dstVal) & $past(srcVal))) else $error("and value");
	and_zero_sign_a: assert property (takeAnd |=> flagsOut[6] == (result == 8'h00) && flagsOut[5] == result[7])
		else $error("and zero sign");
	and_kept_a: assert property (takeAnd |=> !flagsOut[4] && flagsOut[7] == $past(flagsIn[7])
		&& flagsOut[3:2] == $past(flagsIn[3:2])) else $error("and kept");
	add_sum_a: assert property (takeAdd |=> result == 8'($past(dstVal) + $past(srcVal))) else $error("add sum");
	add_flags_a: assert property (takeAdd |=> flagsOut[7] == (result < $past(dstVal)) && !flagsOut[3]
		&& flagsOut[2] == (result[3:0] < $past(dstVal[3:0]))) else $error("add flags");
	band_sign_a: assert property (tk && opcode == 8'h67 |=> !flagsOut[5] && flagsOut[7] == $past(flagsIn[7]))
		else $error("bit and sign");
	dst_write_pulse_a: assert property (writeDst |-> done && known) else $error("dst write without done");
endmodule // aab_exec_props
bind aab_exec aab_exec_props aab_exec_props_i (.clk(clk), .rst(rst), .ce(ce), .start(start), .done(done),
	.known(known), .writeDst(writeDst), .busy(busy), .opcode(opcode), .dstVal(dstVal), .srcVal(srcVal),
	.flagsIn(flagsIn), .result(result), .flagsOut(flagsOut));

/* bench/add_and_bitand_exec_tb.sv */
// Self-checking bench for the execution block
`timescale 1ns/1ps
module add_and_bitand_exec_tb;
	reg         clk = 0, rst = 1, ce = 1, start = 0;
	reg  [7:0]  opcode = 0, byte2 = 0, dstVal = 0, srcVal = 0, flagsIn = 0, r, f;
	reg  [95:0] opList = 96'h0203_0405_0652_5354_5556_6712;
	wire        done, known, writeDst, writeWorking, busy;
	wire [7:0]  result, flagsOut;
	wire [3:0]  workingReg, instrCycles;
	wire [1:0]  instrLen;
	integer     errors = 0, compares = 0, cyc = 0, i, k;
	always #5 clk = ~clk;
	aab_exec aab_exec_i (.clk(clk), .rst(rst), .ce(ce), .start(start), .opcode(opcode), .byte2(byte2),
		.dstVal(dstVal), .srcVal(srcVal), .flagsIn(flagsIn), .done(done), .known(known), .result(result),
		.flagsOut(flagsOut), .writeDst(writeDst), .writeWorking(writeWorking), .workingReg(workingReg),
		.instrLen(instrLen), .instrCycles(instrCycles), .busy(busy));
	task test_done;
		begin
			$display("errors %0d compares %0d", errors, compares);
			if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task run(input [7:0] op, input [7:0] b2);
		reg [7:0] d, s;
		reg [8:0] sum;
		reg       bt, kn;
		reg [1:0] fr;
		begin
			d = $urandom;
			s = $urandom;
			f = $urandom;
			kn = op != 8'h12;
			fr = $urandom % 3;
			@(negedge clk);
			{opcode, byte2, dstVal, srcVal, flagsIn, start} = {op, b2, d, s, f, 1'b1};
			@(negedge clk);
			// Second request while busy must be ignored
			dstVal = ~d;
			@(negedge clk);
			start = 0;
			// A frozen ce must stretch the op; ignoring it would end early
			if (fr != 0) begin
				ce = 0;
				repeat (fr) @(negedge clk);
				ce = 1;
			end
			k = 1;
			while (done !== 1'b1 && k < 9) begin
				@(negedge clk);
				k = k + 1;
			end
			sum = d + s;
			r = d & s;
			if (op < 8'h10) begin
				r = sum[7:0];
				f[7:2] = {sum[8], r == 0, r[7], d[7] == s[7] && r[7] != d[7], 1'b0, (d & 15) + (s & 15) > 15};
			end else if (op < 8'h60)
				f[6:4] = {r == 0, r[7], 1'b0};
			else begin
				r = d;
				bt = b2[0] ? d[b2[3:1]] & s[0] : s[b2[3:1]] & d[0];
				if (b2[0]) r[b2[3:1]] = bt;
				else r[0] = bt;
				f[6:5] = {!bt, 1'b0};
			end
			chk(k[7:0], (op == 8'h02 || op == 8'h52 || !kn) ? 8'd3 : 8'd5);
			chk(known, kn);
			chk(writeDst, kn && !(op == 8'h67 && !b2[0]));
			chk(writeWorking, op == 8'h67 && !b2[0]);
			chk(instrCycles, (op == 8'h02 || op == 8'h52 || !kn) ? 8'h04 : 8'h06);
			chk(workingReg, b2[7:4]);
			chk(busy, 0);
			if (kn) begin
				chk(result, r);
				chk(flagsOut, f);
				chk(instrLen, (op[3:0] < 4) ? 8'd2 : 8'd3);
			end
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors = errors + 1;
			test_done;
		end
	end
	initial begin
		i = $urandom(32'he7d2);
		repeat (10) @(negedge clk);
		chk(busy, 0);
		rst = 0;
		for (i = 0; i < 120; i = i + 1) run(opList[8 * (i % 12) +: 8], $urandom);
		test_done;
	end
endmodule // add_and_bitand_exec_tb
